// >>> pkg/tsa_regs.vh
// register indexes, field positions, reset values and timing counts of the
// status, alert, overtemp, offset and one-shot block.
// assumes the byte address on the bus is four times the register index.
`ifndef TSA_REGS_VH
`define TSA_REGS_VH

// register indexes (byte address = index * 4)
`define TSA_IDX_STATUS_PRIMARY     6'h02
`define TSA_IDX_CONFIG             6'h03
`define TSA_IDX_ONE_SHOT           6'h0F
`define TSA_IDX_R1_OFFSET_UPPER    6'h11
`define TSA_IDX_R1_OFFSET_LOWER    6'h12
`define TSA_IDX_OT_HYSTERESIS      6'h21
`define TSA_IDX_STATUS_SECONDARY   6'h23
`define TSA_IDX_R2_OFFSET_UPPER    6'h34
`define TSA_IDX_R2_OFFSET_LOWER    6'h35

// configuration register fields
`define TSA_CFG_ALERT_MASK         0
`define TSA_CFG_PIN_OVERTEMP2      1
`define TSA_CFG_STANDBY            2
`define TSA_CFG_REMOTE2_SELECT     3
`define TSA_CFG_RESET              8'h00

// primary status fields
`define TSA_ST1_BUSY               7
`define TSA_ST1_LOCAL_HIGH         6
`define TSA_ST1_LOCAL_LOW          5
`define TSA_ST1_R1_HIGH            4
`define TSA_ST1_R1_LOW             3
`define TSA_ST1_R1_OPEN            2
`define TSA_ST1_R1_OVERTEMP        1
`define TSA_ST1_LOCAL_OVERTEMP     0

// secondary status fields
`define TSA_ST2_R2_HIGH            4
`define TSA_ST2_R2_LOW             3
`define TSA_ST2_R2_OPEN            2
`define TSA_ST2_R2_OVERTEMP        1
`define TSA_ST2_ALERT_ACTIVE       0

// reset values
`define TSA_HYST_RESET             8'h0A
`define TSA_OFFSET_RESET           8'h00

// one-shot request pulse length in mclk cycles
`define TSA_ONE_SHOT_PULSE_CYCLES  1

`endif

// >>> core/tsa_chan_cmp.v
// one channel of limit comparison: high and low trips plus two hysteresis
// states (overtemp limit and high limit), all updated on a measurement strobe.
// assumes meas and limits are signed quarter-degree codes of equal width.
`timescale 1ns/10ps

module tsa_chan_cmp #(
    parameter W = 10
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst,
    // measurement strobe and value
    input  wire         update,
    input  wire [W-1:0] meas,
    // limits (quarter-degree codes) and hysteresis (whole degrees)
    input  wire [W-1:0] high_lim,
    input  wire [W-1:0] low_lim,
    input  wire [W-1:0] ot_lim,
    input  wire [7:0]   hyst,
    // comparison results
    output reg          high_trip,
    output reg          low_trip,
    output reg          ot_state,
    output reg          high_state
);

    // widen to keep limit minus hysteresis from wrapping
    localparam XW = W + 4;

    wire signed [XW-1:0] s_meas  = {{4{meas[W-1]}}, meas};
    wire signed [XW-1:0] s_high  = {{4{high_lim[W-1]}}, high_lim};
    wire signed [XW-1:0] s_low   = {{4{low_lim[W-1]}}, low_lim};
    wire signed [XW-1:0] s_ot    = {{4{ot_lim[W-1]}}, ot_lim};
    wire signed [XW-1:0] s_hyst  = {{(XW-10){1'b0}}, hyst, 2'b00};
    wire signed [XW-1:0] ot_rel  = s_ot - s_hyst;
    wire signed [XW-1:0] hi_rel  = s_high - s_hyst;

    // comparisons are taken only when a fresh measurement arrives
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            high_trip  <= 1'b0;
            low_trip   <= 1'b0;
            ot_state   <= 1'b0;
            high_state <= 1'b0;
        end
        else if (update)
        begin
            high_trip <= (s_meas > s_high);
            low_trip  <= (s_meas <= s_low);
            if (s_meas > s_ot)
                ot_state <= 1'b1;
            else if (s_meas < ot_rel)
                ot_state <= 1'b0;
            // same hysteresis for the second output
            if (s_meas > s_high)
                high_state <= 1'b1;
            else if (s_meas < hi_rel)
                high_state <= 1'b0;
        end
    end

endmodule // tsa_chan_cmp

// >>> core/tsa_top.v
// status flags, alert latch, overtemp outputs, remote offset calibration and
// one-shot trigger of a three-channel temperature monitor, as a classic
// wishbone slave with 8-bit registers in the low lane of a 32-bit word.
// assumes the converter supplies raw readings with a one-cycle valid strobe,
// and the smbus front end pulses alert_response when the host has read the
// alert-response address. limits arrive as plain inputs.
//
// Overview of operation
// - two read-only status registers, primary at 0x02, secondary at 0x23
// - primary bit 7 shows conversion busy, never drives alert
// - primary bits 6..3 flag local high/low and remote-1 high/low trips
// - primary bit 2 flags open remote-1 diode, alert capable
// - primary bits 1,0 show remote-1 and local overtemp, not alert capable
// - secondary bits 7..5 reserved; bits 4,3 flag remote-2 high/low trips
// - secondary bit 2 open remote-2 diode; bit 1 remote-2 overtemp
// - alert-capable flags stay set until status read or reset
// - any unmasked alert flag sets alert latch and pulls alert low
// - primary read clears bits 6..2 only where condition has gone
// - secondary read clears bits 4..2 only where condition has gone
// - flag clears only for in-limit value or good diode
// - alert latch cleared by alert-response read once flags are clear or masked
// - overtemp output low while any overtemp flag set, self releasing
// - overtemp releases below limit minus hysteresis at 0x21
// - second overtemp mode: alert pin follows high-limit states only
// - secondary bit 0 follows alert output in alert mode only, stays clear when masked
// - remote-1 offset is 10-bit: upper byte 0x11, fraction in 0x12[7:6]
// - remote-2 offset at 0x34/0x35; select bit redirects 0x11/0x12
// - signed offset added to each remote reading, resets to zero
// - write to 0x0F in standby starts one pass, data not stored
// - high limit trips above, low limit trips at or below
// - hysteresis defaults to 10 degrees, used by both overtemp outputs
`timescale 1ns/10ps
`include "tsa_regs.vh"

module tsa_top #(
    parameter W = 10
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst,
    // wishbone classic slave
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [7:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output reg  [31:0]  wb_dat_o,
    output reg          wb_ack_o,
    // converter side
    input  wire         conv_busy,
    input  wire         meas_valid,
    input  wire [W-1:0] local_meas,
    input  wire [W-1:0] remote1_raw,
    input  wire [W-1:0] remote2_raw,
    input  wire         remote1_open,
    input  wire         remote2_open,
    output reg          one_shot_start,
    output reg          standby,
    // limits (signed quarter-degree codes)
    input  wire [W-1:0] local_high_lim,
    input  wire [W-1:0] local_low_lim,
    input  wire [W-1:0] local_ot_lim,
    input  wire [W-1:0] remote1_high_lim,
    input  wire [W-1:0] remote1_low_lim,
    input  wire [W-1:0] remote1_ot_lim,
    input  wire [W-1:0] remote2_high_lim,
    input  wire [W-1:0] remote2_low_lim,
    input  wire [W-1:0] remote2_ot_lim,
    // smbus alert-response completion
    input  wire         alert_response,
    // pins: open-drain alert pin, overtemp output
    output reg          alert_pin_o,
    output reg          alert_pin_oe_n,
    output reg          overtemp_out_n,
    // corrected remote readings
    output reg  [W-1:0] remote1_corr,
    output reg  [W-1:0] remote2_corr
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // saturating signed add; clipping keeps a big offset from wrapping
    function [W-1:0] sat_add;
        input [W-1:0] a;
        input [W-1:0] b;
        reg   [W:0]   s;
        begin
            s = {a[W-1], a} + {b[W-1], b};
            if (s[W] != s[W-1])
                sat_add = s[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
            else
                sat_add = s[W-1:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    wire [5:0] idx     = wb_adr_i[7:2];
    wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr_req  = req & wb_we_i & wb_sel_i[0];
    wire       rd_req  = req & ~wb_we_i;

    reg  [7:0] cfg;
    reg  [7:0] hyst;
    reg  [7:0] r1_off_hi;
    reg  [1:0] r1_off_lo;
    reg  [7:0] r2_off_hi;
    reg  [1:0] r2_off_lo;

    // select bit steers the remote-1 offset window
    wire       r2_sel  = cfg[`TSA_CFG_REMOTE2_SELECT];
    wire       hit_ou  = (idx == `TSA_IDX_R1_OFFSET_UPPER);
    wire       hit_ol  = (idx == `TSA_IDX_R1_OFFSET_LOWER);
    wire       wr_r1hi = wr_req & hit_ou & ~r2_sel;
    wire       wr_r1lo = wr_req & hit_ol & ~r2_sel;
    wire       wr_r2hi = wr_req & ((hit_ou & r2_sel) | (idx == `TSA_IDX_R2_OFFSET_UPPER));
    wire       wr_r2lo = wr_req & ((hit_ol & r2_sel) | (idx == `TSA_IDX_R2_OFFSET_LOWER));

    // clear-on-read acts at the edge the read is acknowledged
    wire       rd_st1  = rd_req & (idx == `TSA_IDX_STATUS_PRIMARY);
    wire       rd_st2  = rd_req & (idx == `TSA_IDX_STATUS_SECONDARY);

    // ------------------------------------------------------------------
    // configuration, hysteresis and offset registers
    // ------------------------------------------------------------------

    // software-written registers; offsets reset to zero
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cfg       <= `TSA_CFG_RESET;
            hyst      <= `TSA_HYST_RESET;
            r1_off_hi <= `TSA_OFFSET_RESET;
            r1_off_lo <= 2'h0;
            r2_off_hi <= `TSA_OFFSET_RESET;
            r2_off_lo <= 2'h0;
        end
        else
        begin
            if (wr_req & (idx == `TSA_IDX_CONFIG))
                cfg <= {4'h0, wb_dat_i[3:0]};
            if (wr_req & (idx == `TSA_IDX_OT_HYSTERESIS))
                hyst <= wb_dat_i[7:0];
            if (wr_r1hi)
                r1_off_hi <= wb_dat_i[7:0];
            if (wr_r1lo)
                r1_off_lo <= wb_dat_i[7:6];
            // remote-2 offset at its own and redirected addresses
            if (wr_r2hi)
                r2_off_hi <= wb_dat_i[7:0];
            if (wr_r2lo)
                r2_off_lo <= wb_dat_i[7:6];
        end
    end

    // ------------------------------------------------------------------
    // one-shot trigger and standby
    // ------------------------------------------------------------------

    // write strobe only; written data is dropped
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            one_shot_start <= 1'b0;
            standby        <= 1'b0;
        end
        else
        begin
            one_shot_start <= wr_req & (idx == `TSA_IDX_ONE_SHOT)
                              & cfg[`TSA_CFG_STANDBY];
            standby        <= cfg[`TSA_CFG_STANDBY];
        end
    end

    // ------------------------------------------------------------------
    // offset correction and channel comparison
    // ------------------------------------------------------------------

    // offsets applied to both remote readings
    wire [W-1:0] r1_adj = sat_add(remote1_raw, {r1_off_hi, r1_off_lo});
    wire [W-1:0] r2_adj = sat_add(remote2_raw, {r2_off_hi, r2_off_lo});

    // corrected readings held for the value registers outside
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            remote1_corr <= {W{1'b0}};
            remote2_corr <= {W{1'b0}};
        end
        else if (meas_valid)
        begin
            remote1_corr <= r1_adj;
            remote2_corr <= r2_adj;
        end
    end

    wire l_hi;
    wire l_lo;
    wire l_ot;
    wire l_hs;
    wire r1_hi;
    wire r1_lo;
    wire r1_ot;
    wire r1_hs;
    wire r2_hi;
    wire r2_lo;
    wire r2_ot;
    wire r2_hs;

    tsa_chan_cmp #(.W(W)) u_local (
        .mclk       (mclk),
        .rst        (rst),
        .update     (meas_valid),
        .meas       (local_meas),
        .high_lim   (local_high_lim),
        .low_lim    (local_low_lim),
        .ot_lim     (local_ot_lim),
        .hyst       (hyst),
        .high_trip  (l_hi),
        .low_trip   (l_lo),
        .ot_state   (l_ot),
        .high_state (l_hs)
    );

    tsa_chan_cmp #(.W(W)) u_remote1 (
        .mclk       (mclk),
        .rst        (rst),
        .update     (meas_valid),
        .meas       (r1_adj),
        .high_lim   (remote1_high_lim),
        .low_lim    (remote1_low_lim),
        .ot_lim     (remote1_ot_lim),
        .hyst       (hyst),
        .high_trip  (r1_hi),
        .low_trip   (r1_lo),
        .ot_state   (r1_ot),
        .high_state (r1_hs)
    );

    tsa_chan_cmp #(.W(W)) u_remote2 (
        .mclk       (mclk),
        .rst        (rst),
        .update     (meas_valid),
        .meas       (r2_adj),
        .high_lim   (remote2_high_lim),
        .low_lim    (remote2_low_lim),
        .ot_lim     (remote2_ot_lim),
        .hyst       (hyst),
        .high_trip  (r2_hi),
        .low_trip   (r2_lo),
        .ot_state   (r2_ot),
        .high_state (r2_hs)
    );

    // ------------------------------------------------------------------
    // sticky alert flags
    // ------------------------------------------------------------------

    // live conditions, order: lh ll r1h r1l d1 | r2h r2l d2
    // limit trips and open-diode inputs
    wire [4:0] cond1 = {l_hi, l_lo, r1_hi, r1_lo, remote1_open};
    wire [2:0] cond2 = {r2_hi, r2_lo, remote2_open};

    reg  [4:0] flag1;
    reg  [2:0] flag2;

    // set wins over clear so a trip during the read is kept
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flag1 <= 5'h00;
            flag2 <= 3'h0;
        end
        else
        begin
            // only in-limit or good diode clears
            flag1 <= (flag1 & ~({5{rd_st1}} & ~cond1)) | cond1;
            flag2 <= (flag2 & ~({3{rd_st2}} & ~cond2)) | cond2;
        end
    end

    // ------------------------------------------------------------------
    // alert latch and pin
    // ------------------------------------------------------------------

    // masked flags never reach the latch; busy and overtemp excluded
    wire any_flag = ~cfg[`TSA_CFG_ALERT_MASK] & (|{flag1, flag2});
    wire pin_ot2  = cfg[`TSA_CFG_PIN_OVERTEMP2];
    reg  alert_latch;

    // latch set beats an alert-response clear in the same cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            alert_latch <= 1'b0;
        else if (any_flag)
            alert_latch <= 1'b1;
        // only an alert-response read with flags clear or masked releases it
        else if (alert_response)
            alert_latch <= 1'b0;
    end

    // alert-active bit mirrors the pin in alert mode
    wire alert_active = alert_latch & ~pin_ot2;

    // open-drain pins; enable low while pulling low
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            alert_pin_o    <= 1'b0;
            alert_pin_oe_n <= 1'b1;
            overtemp_out_n <= 1'b1;
        end
        else
        begin
            alert_pin_o    <= 1'b0;
            // second overtemp follows high-limit states only
            if (pin_ot2)
                alert_pin_oe_n <= ~(l_hs | r1_hs | r2_hs);
            else
                alert_pin_oe_n <= ~alert_latch;
            // overtemp output follows the hysteresis states
            overtemp_out_n <= ~(l_ot | r1_ot | r2_ot);
        end
    end

    // ------------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------------

    wire [7:0] st1 = {conv_busy, flag1, r1_ot, l_ot};
    wire [7:0] st2 = {3'h0, flag2, r2_ot, alert_active};

    reg  [7:0] rd_mux;

    // status registers are read only: writes to them are ignored
    always @*
    begin
        rd_mux = 8'h00;
        case (idx)
            `TSA_IDX_STATUS_PRIMARY:   rd_mux = st1;
            `TSA_IDX_STATUS_SECONDARY: rd_mux = st2;
            `TSA_IDX_CONFIG:           rd_mux = cfg;
            `TSA_IDX_OT_HYSTERESIS:    rd_mux = hyst;
            `TSA_IDX_R1_OFFSET_UPPER:  rd_mux = r2_sel ? r2_off_hi : r1_off_hi;
            `TSA_IDX_R1_OFFSET_LOWER:  rd_mux = {(r2_sel ? r2_off_lo : r1_off_lo), 6'h00};
            `TSA_IDX_R2_OFFSET_UPPER:  rd_mux = r2_off_hi;
            `TSA_IDX_R2_OFFSET_LOWER:  rd_mux = {r2_off_lo, 6'h00};
            default:                   rd_mux = 8'h00;
        endcase
    end

    // one wait state; unmapped addresses still ack and read zero
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req;
            if (rd_req)
                wb_dat_o <= {24'h000000, rd_mux};
        end
    end

endmodule // tsa_top

// >>> tb/tsa_host_model.sv
// far side: smbus host that answers a low alert pin with an alert-response read
// assumes the bench resolves the open-drain pin with a pull-up
`timescale 1ns/10ps

module tsa_host_model #(
    parameter [7:0] DELAY = 8'h03
) (
    // clock and reset
    input  wire       mclk,
    input  wire       rst,
    // service enable, device standby, pin level
    input  wire       svc_en,
    input  wire       standby,
    input  wire       alert_lvl,
    // one-cycle pulse: alert-response read done
    output reg        alert_response
);
    reg [7:0] wait_cnt;

    // ignore pin in standby, although tsa_top keeps driving its outputs there
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt       <= 8'h00;
            alert_response <= 1'b0;
        end
        else
        begin
            alert_response <= 1'b0;
            if (!svc_en || standby || alert_lvl)
                wait_cnt <= 8'h00;
            else if (wait_cnt == DELAY)
            begin
                wait_cnt       <= 8'h00;
                alert_response <= 1'b1;
            end
            else
                wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule // tsa_host_model

// >>> tb/tsa_properties.sv
// checker: bus, one-shot, alert and overtemp relations at the top ports
// assumes one mclk domain with asynchronous active-high rst
`timescale 1ns/10ps

module tsa_properties #(
    parameter W = 10
) (
    // clock, reset, bus
    input wire         mclk,
    input wire         rst,
    input wire         wb_cyc_i,
    input wire         wb_stb_i,
    input wire         wb_we_i,
    input wire [7:0]   wb_adr_i,
    input wire [31:0]  wb_dat_o,
    input wire         wb_ack_o,
    // converter and pins
    input wire         conv_busy,
    input wire         meas_valid,
    input wire [W-1:0] local_meas,
    input wire [W-1:0] local_ot_lim,
    input wire         one_shot_start,
    input wire         standby,
    input wire         alert_response,
    input wire         alert_pin_o,
    input wire         alert_pin_oe_n,
    input wire         overtemp_out_n
);
    // cycles since the last event allowed to release a pin
    reg [7:0] since_evt;
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            since_evt <= 8'hFF;
        else if (meas_valid || alert_response || (wb_ack_o && wb_we_i))
            since_evt <= 8'h00;
        else if (since_evt != 8'hFF)
            since_evt <= since_evt + 8'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ack_timely_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    data_upper_a: assert property (wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
        else $error("upper read data not zero");
    reserved_zero_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 8'h8C)
        |-> (wb_dat_o[7:5] == 3'h0)) else $error("reserved status bits set");
    busy_live_a: assert property ((wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h08) |=> (wb_dat_o[7] == $past(conv_busy)))
        else $error("busy bit wrong");
    one_shot_a: assert property (one_shot_start |-> $past(wb_cyc_i && wb_stb_i
        && wb_we_i && wb_adr_i == 8'h3C && standby) ##1 !one_shot_start)
        else $error("one-shot pulse without standby write");
    alert_drive_a: assert property (alert_pin_o == 1'b0)
        else $error("alert pin driven high");
    overtemp_set_a: assert property ((meas_valid
        && ($signed(local_meas) > $signed(local_ot_lim))) |-> ##[1:3] !overtemp_out_n)
        else $error("overtemp output not asserted");
    overtemp_rel_a: assert property ($rose(overtemp_out_n) |-> (since_evt <= 8'h04))
        else $error("overtemp released without measurement");
    alert_rel_a: assert property ($rose(alert_pin_oe_n) |-> (since_evt <= 8'h04))
        else $error("alert released without service");
endmodule // tsa_properties

bind tsa_top tsa_properties #(.W(W)) u_props (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_busy(conv_busy), .meas_valid(meas_valid), .local_meas(local_meas),
    .local_ot_lim(local_ot_lim), .one_shot_start(one_shot_start), .standby(standby),
    .alert_response(alert_response), .alert_pin_o(alert_pin_o),
    .alert_pin_oe_n(alert_pin_oe_n), .overtemp_out_n(overtemp_out_n));

// >>> tb/tb_top.sv
// bench: wishbone register tests of the status, alert, overtemp, offset block
// assumes tsa_top with W=10 and the host model servicing the alert pin
`timescale 1ns/10ps

module tb_top;
    reg         mclk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, mv = 1'b0, cb = 1'b0;
    reg         op1 = 1'b0, op2 = 1'b0, svc = 1'b0, s0 = 1'b1;
    reg  [7:0]  adr = 8'h00, q, m, e;
    reg  [31:0] dat = 32'h0;
    reg  [9:0]  lm = 10'd100, r1 = 10'd100, r2 = 10'd100;
    reg  [9:0]  hi = 10'd320, lo = 10'd0, ot = 10'd340;
    wire [31:0] rdat;
    wire [9:0]  c1, c2;
    wire        ack, oss, sby, ar, apo, aoe_n, otn;
    wire        alert_lvl = aoe_n ? 1'b1 : apo;  // pull-up on the open-drain pin
    integer     bad_count = 0, total_checks = 0, os_count = 0, i;

    always #25 mclk = ~mclk;
    always @(posedge mclk) if (oss === 1'b1) os_count = os_count + 1;

    tsa_top #(.W(10)) DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i({3'h0, s0}), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .conv_busy(cb), .meas_valid(mv), .local_meas(lm),
        .remote1_raw(r1), .remote2_raw(r2), .remote1_open(op1), .remote2_open(op2),
        .one_shot_start(oss), .standby(sby), .local_high_lim(hi), .local_low_lim(lo),
        .local_ot_lim(ot), .remote1_high_lim(hi), .remote1_low_lim(lo),
        .remote1_ot_lim(ot), .remote2_high_lim(hi), .remote2_low_lim(lo),
        .remote2_ot_lim(ot), .alert_response(ar), .alert_pin_o(apo),
        .alert_pin_oe_n(aoe_n), .overtemp_out_n(otn), .remote1_corr(c1),
        .remote2_corr(c2));

    tsa_host_model #(.DELAY(3)) u_host (.mclk(mclk), .rst(rst), .svc_en(svc),
        .standby(sby), .alert_lvl(alert_lvl), .alert_response(ar));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic cycle: hold until ack is sampled, then release for a cycle
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        integer n;
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge mclk);
            n = n + 1;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        req <= 1'b0;
        if (ack !== 1'b1)
        begin
            bad_count = bad_count + 1;
            $display("BAD bus ack expected 1 seen %b", ack);
            finish_test;
        end
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        check("read data", {24'h0, q}, {24'h0, exp});
    endtask
    // one measurement strobe, then let flags and pins settle
    task meas;
        @(posedge mclk);
        mv <= 1'b1;
        @(posedge mclk);
        mv <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // raise or remove one alert-capable condition
    task apply(input integer k, input logic on);
        case (k)
            0: lm <= on ? 10'd324 : 10'd100;
            1: lm <= on ? 10'd0 : 10'd100;
            2: r1 <= on ? 10'd324 : 10'd100;
            3: r1 <= on ? 10'd0 : 10'd100;
            4: op1 <= on;
            5: r2 <= on ? 10'd324 : 10'd100;
            6: r2 <= on ? 10'd0 : 10'd100;
            default: op2 <= on;
        endcase
        meas;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        s0 <= 1'b0;
        wb(1'b1, 8'h84, 8'h55);
        s0 <= 1'b1;
        rdc(8'h84, 8'h0A);
        rdc(8'h44, 8'h00);
        rdc(8'hD4, 8'h00);
        rdc(8'h8C, 8'h00);
        rdc(8'hFC, 8'h00);
        cb <= 1'b1;
        wb(1'b1, 8'h08, 8'hFF);
        rdc(8'h08, 8'h80);
        cb <= 1'b0;
        // every alert flag: set, held, sticky, cleared only when gone
        for (i = 0; i < 8; i = i + 1)
        begin
            m = 8'h01 << ((i < 5) ? 6 - i : 9 - i);
            e = (i < 5) ? 8'h00 : 8'h01;
            apply(i, 1'b1);
            rdc((i < 5) ? 8'h08 : 8'h8C, e | m);
            rdc((i < 5) ? 8'h08 : 8'h8C, e | m);
            apply(i, 1'b0);
            rdc((i < 5) ? 8'h08 : 8'h8C, e | m);
            rdc((i < 5) ? 8'h08 : 8'h8C, e);
        end
        check("alert pin", alert_lvl, 1'b0);
        svc <= 1'b1;
        repeat (30) @(posedge mclk);
        check("alert pin", alert_lvl, 1'b1);
        rdc(8'h8C, 8'h00);
        // masked alert
        wb(1'b1, 8'h0C, 8'h01);
        apply(0, 1'b1);
        check("alert pin", alert_lvl, 1'b1);
        rdc(8'h8C, 8'h00);
        apply(0, 1'b0);
        rdc(8'h08, 8'h40);
        wb(1'b1, 8'h0C, 8'h00);
        // overtemp with hysteresis of 40 codes
        lm <= 10'd344;
        meas;
        check("overtemp", otn, 1'b0);
        rdc(8'h08, 8'h41);
        lm <= 10'd304;
        meas;
        check("overtemp", otn, 1'b0);
        lm <= 10'd296;
        meas;
        check("overtemp", otn, 1'b1);
        rdc(8'h08, 8'h40);
        rdc(8'h08, 8'h00);
        // alert pin as second overtemp output
        wb(1'b1, 8'h0C, 8'h02);
        lm <= 10'd324;
        meas;
        check("second overtemp", alert_lvl, 1'b0);
        lm <= 10'd284;
        meas;
        check("second overtemp", alert_lvl, 1'b0);
        lm <= 10'd0;
        meas;
        check("second overtemp", alert_lvl, 1'b1);
        lm <= 10'd100;
        meas;
        rdc(8'h08, 8'h60);
        wb(1'b1, 8'h0C, 8'h00);
        // one-shot only in standby, data not kept
        wb(1'b1, 8'h3C, 8'h5A);
        check("one-shot count", os_count, 0);
        wb(1'b1, 8'h0C, 8'h04);
        @(posedge mclk);
        check("standby", sby, 1'b1);
        wb(1'b1, 8'h3C, 8'hA5);
        repeat (2) @(posedge mclk);
        check("one-shot count", os_count, 1);
        rdc(8'h3C, 8'h00);
        wb(1'b1, 8'h0C, 8'h00);
        // offsets: remote-1 +4.25, remote-2 -4 through the select bit
        wb(1'b1, 8'h44, 8'h04);
        wb(1'b1, 8'h48, 8'h40);
        rdc(8'h48, 8'h40);
        wb(1'b1, 8'h0C, 8'h08);
        wb(1'b1, 8'h44, 8'hFC);
        wb(1'b1, 8'h0C, 8'h00);
        rdc(8'hD0, 8'hFC);
        rdc(8'h44, 8'h04);
        meas;
        check("remote1 corrected", c1, 10'd117);
        check("remote2 corrected", c2, 10'd84);
        finish_test;
    end
endmodule // tb_top
